/* File: rtl/spd_consts.svh */
// Constants for the presence-detect EEPROM serial slave engine.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

// Select byte layout
`define SEL_TYPE_HI     7
`define SEL_TYPE_LO     4
`define SEL_CS_HI       3
`define SEL_CS_LO       1
`define SEL_RW_BIT      0
`define TYPE_MEM        4'hA
`define TYPE_PROT       4'h6
`define CS_SET_PROT     3'h1
`define CS_CLR_PROT     3'h3

// Array geometry
`define MEM_DEPTH       256
`define ADDR_W          8
`define DATA_W          8
`define PAGE_BITS       4
`define LOW_HALF_BIT    7
`define MEM_RESET       8'hFF

// Receive and transmit bit counts
`define BITS_PER_BYTE   4'h8
`define BIT_LAST_IN     4'h7

// Write cycle timing: time in microseconds, clock in MHz
`define CLK_MHZ         50
`define TW_US           5000
`define WR_PACE_CYC     4'hF

// Page buffer
`define PAGE_DEPTH      16
`define FIFO_W          16

`endif

/* File: rtl/spd_pkg.sv */
// Types shared by the presence-detect EEPROM serial slave engine.
// Assumes nothing beyond the constants header.
package spd_pkg;

    // Byte engine states
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_BUSY
    } state_t;

    // Meaning of the byte being received
    typedef enum logic [1:0] {KIND_SEL, KIND_ADDR, KIND_DATA} kind_t;

    // Instruction selected by the select byte
    typedef enum logic [1:0] {OP_MEM, OP_SWP, OP_CWP, OP_PERMANENT_PROTECT_CMD} op_t;

endpackage

/* File: rtl/spd_eeprom_i2c_slave.sv */
// Two-wire slave engine of a 256-byte presence-detect EEPROM, with a
// page buffer FIFO and a two-flop synchroniser.
// Assumes serial lines arrive asynchronously and are sampled at 50 MHz;
// protection state is mirrored out for an outside non-volatile store.
//
// How it works
// - Select type 1010 reaches the array, 0110 reaches protection settings.
// - Array and permanent-protect selects respond only when chip-select bits equal the three pin levels.
// - Select byte bit 0 is direction: one reads, zero writes.
// - Matching select byte acknowledged in slot nine; mismatch goes standby.
// - Write guard high blocks every write; master holds it steady.
// - Software protection blocks lower half; guard low otherwise permits.
// - Protection state kept non-volatile, reloaded after power returns.
// - Set and clear protect use byte-write frame, high voltage on pin0.
// - Permanent protect locks lower 128 bytes forever.
// - Once locked, protection-settings select bytes are never acknowledged.
// - Write: acknowledge select, acknowledge address, then take data.
// - Write cycle starts only on Stop right after a data acknowledge.
// - During the write cycle both lines are ignored.
// - Protected data byte gets no acknowledge and memory is unchanged.
// - Page write of one to sixteen bytes commits in one cycle.
// - Page write increments only low four address bits.
// - Busy device withholds select acknowledge; acknowledges when done.
// - Reads work whatever the protection state.
// - Random read: address write without Stop, restart, read one byte.
// - Current read outputs byte at counter then increments counter.
// - Sequential read: master acknowledge gives next byte, wraps to zero.
// - Master no-acknowledge after a read byte ends transfer to standby.
// - Set uses chip bits 001, clear 011, permanent uses pin levels.
`timescale 1ns/10ps
`include "spd_consts.svh"

// Two-flop synchroniser for a group of asynchronous levels
module sync_2ff #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First flop feeds only the second one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RST; // Idle level, so no false edge after reset
            q      <= RST;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // sync_2ff

// Flop-based FIFO with valid and ready on both sides
module page_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         clr,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage needs no reset; pointers decide what is valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // Pointers and fill count; clear drops everything
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (clr) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // page_fifo

module spd_eeprom_i2c_slave #(
    parameter int unsigned TW_CYCLES = `TW_US * `CLK_MHZ
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Serial bus, open drain data
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Straps and guard
    input  wire logic chip_sel_pin0,
    input  wire logic chip_sel_pin1,
    input  wire logic chip_sel_pin2,
    input  wire logic high_voltage_level,
    input  wire logic write_guard_n,
    // Non-volatile protection image
    input  wire logic nv_soft_prot_init,
    input  wire logic nv_perm_prot_init,
    output logic      soft_prot,
    output logic      perm_prot,
    // Status
    output logic      write_busy
);
    spd_pkg::state_t state_r;
    spd_pkg::kind_t  kind_r;
    spd_pkg::op_t    op_r;
    spd_pkg::op_t    op_nxt;
    logic [6:0]  syn;
    logic        scl_s, sda_s, guard_s, hv_s;
    logic [2:0]  pins_s;
    logic        scl_d_r, sda_d_r;
    logic        scl_rise, scl_fall, start_c, stop_c;
    logic [7:0]  shreg_r;
    logic [3:0]  bitcnt_r;
    logic        ack_r, rw_r, armed_r, loaded_r;
    logic [7:0]  addr_r;
    logic [7:0]  mem_r [`MEM_DEPTH];
    logic [23:0] tw_cnt_r;
    logic [3:0]  pace_r;
    logic        byte_end, rel_ack, tx_load, ack_now, begin_wr, wr_done;
    logic        low_locked, mem_ok, sel_mem, swp_ok, cwp_ok, permanent_protect_cmd_ok;
    logic        data_push, f_in_ready, f_out_valid, f_pop;
    logic [15:0] f_out_data;

    // Serial lines start at their released high level
    sync_2ff #(.W(7), .RST(7'h60)) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({scl_in, sda_in, write_guard_n, chip_sel_pin2,
                  chip_sel_pin1, chip_sel_pin0, high_voltage_level}),
        .q      (syn)
    );
    assign {scl_s, sda_s, guard_s, pins_s, hv_s} = syn;

    // Delayed copies of synchronised lines for edge finding
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Bus events; start and stop need the clock high on both samples
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;

    // Select byte decode, on the complete received byte
    assign sel_mem = shreg_r[7:4] == `TYPE_MEM
                  && shreg_r[3:1] == pins_s;
    assign swp_ok  = shreg_r[3:1] == `CS_SET_PROT && hv_s
                  && !pins_s[1] && !pins_s[2] && !soft_prot;
    assign cwp_ok  = shreg_r[3:1] == `CS_CLR_PROT && hv_s
                  && pins_s[1] && !pins_s[2];
    assign permanent_protect_cmd_ok = shreg_r[3:1] == pins_s;

    // Lower half locked by software or permanent protection
    assign low_locked = (soft_prot || perm_prot)
                     && !addr_r[`LOW_HALF_BIT];
    // A full page buffer also refuses, so overruns are not silent
    assign mem_ok = !guard_s && !low_locked && f_in_ready;

    // Acknowledge decision for the byte just received
    always_comb begin
        ack_now = 1'b0;
        op_nxt  = spd_pkg::OP_MEM;
        case (kind_r)
            spd_pkg::KIND_SEL: begin
                if (sel_mem) begin
                    ack_now = 1'b1;
                end else if (shreg_r[7:4] == `TYPE_PROT && !perm_prot
                             && !shreg_r[0]) begin
                    if (swp_ok) begin
                        ack_now = 1'b1;
                        op_nxt  = spd_pkg::OP_SWP;
                    end else if (cwp_ok) begin
                        ack_now = 1'b1;
                        op_nxt  = spd_pkg::OP_CWP;
                    end else if (permanent_protect_cmd_ok) begin
                        ack_now = 1'b1;
                        op_nxt  = spd_pkg::OP_PERMANENT_PROTECT_CMD;
                    end
                end
            end
            spd_pkg::KIND_ADDR: begin
                ack_now = 1'b1;
            end
            default: begin
                ack_now = (op_r == spd_pkg::OP_MEM) ? mem_ok : !guard_s;
            end
        endcase
    end

    assign byte_end  = state_r == spd_pkg::ST_RX && scl_fall
                    && bitcnt_r == `BITS_PER_BYTE;
    assign rel_ack   = state_r == spd_pkg::ST_RX_ACK && scl_fall;
    assign tx_load   = (rel_ack && kind_r == spd_pkg::KIND_SEL && ack_r
                        && rw_r)
                    || (state_r == spd_pkg::ST_TX_ACK && scl_fall
                        && ack_r);
    assign data_push = byte_end && kind_r == spd_pkg::KIND_DATA
                    && op_r == spd_pkg::OP_MEM && ack_now;
    assign begin_wr  = stop_c && armed_r
                    && state_r != spd_pkg::ST_BUSY;
    assign f_pop     = state_r == spd_pkg::ST_BUSY && pace_r == '0;
    assign wr_done   = state_r == spd_pkg::ST_BUSY && !f_out_valid
                    && tw_cnt_r >= 24'(TW_CYCLES - 1);

    // Byte engine: receive, acknowledge, transmit, busy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r  <= spd_pkg::ST_IDLE;
            kind_r   <= spd_pkg::KIND_SEL;
            op_r     <= spd_pkg::OP_MEM;
            shreg_r  <= 8'h00;
            bitcnt_r <= 4'h0;
            ack_r    <= 1'b0;
            rw_r     <= 1'b0;
            armed_r  <= 1'b0;
            sda_oe   <= 1'b0;
        end else if (state_r == spd_pkg::ST_BUSY) begin
            sda_oe <= 1'b0;
            if (wr_done) begin
                state_r <= spd_pkg::ST_IDLE;
            end
        end else if (begin_wr) begin
            state_r <= spd_pkg::ST_BUSY;
            armed_r <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (stop_c) begin
            state_r <= spd_pkg::ST_IDLE;
            armed_r <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (start_c) begin
            state_r  <= spd_pkg::ST_RX;
            kind_r   <= spd_pkg::KIND_SEL;
            bitcnt_r <= 4'h0;
            armed_r  <= 1'b0;
            sda_oe   <= 1'b0;
        end else begin
            case (state_r)
                spd_pkg::ST_RX: begin
                    if (scl_rise && bitcnt_r != `BITS_PER_BYTE) begin
                        shreg_r  <= {shreg_r[6:0], sda_s};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (byte_end) begin
                        ack_r   <= ack_now;
                        sda_oe  <= ack_now;
                        state_r <= spd_pkg::ST_RX_ACK;
                        if (kind_r == spd_pkg::KIND_SEL) begin
                            rw_r <= shreg_r[`SEL_RW_BIT];
                            op_r <= op_nxt;
                        end
                    end else if (scl_fall && bitcnt_r != 4'h0) begin
                        // Stop sits in the slot after the ack; a clock
                        // fall ending that slot means more data follows
                        armed_r <= 1'b0;
                    end
                end
                spd_pkg::ST_RX_ACK: begin
                    if (rel_ack) begin
                        sda_oe   <= 1'b0;
                        bitcnt_r <= 4'h0;
                        state_r  <= spd_pkg::ST_RX;
                        if (kind_r == spd_pkg::KIND_SEL) begin
                            if (!ack_r) begin
                                state_r <= spd_pkg::ST_IDLE;
                            end else if (rw_r) begin
                                state_r  <= spd_pkg::ST_TX;
                                shreg_r  <= mem_r[addr_r];
                                sda_oe   <= !mem_r[addr_r][7];
                                bitcnt_r <= 4'h1;
                            end else begin
                                kind_r <= spd_pkg::KIND_ADDR;
                            end
                        end else begin
                            kind_r  <= spd_pkg::KIND_DATA;
                            armed_r <= kind_r == spd_pkg::KIND_DATA
                                    && ack_r;
                        end
                    end
                end
                spd_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_r == `BITS_PER_BYTE) begin
                            sda_oe  <= 1'b0;
                            state_r <= spd_pkg::ST_TX_ACK;
                        end else begin
                            sda_oe   <= !shreg_r[6];
                            shreg_r  <= {shreg_r[6:0], 1'b0};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end
                    end
                end
                spd_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_r <= !sda_s;
                    end else if (scl_fall) begin
                        if (ack_r) begin
                            state_r  <= spd_pkg::ST_TX;
                            shreg_r  <= mem_r[addr_r];
                            sda_oe   <= !mem_r[addr_r][7];
                            bitcnt_r <= 4'h1;
                        end else begin
                            state_r <= spd_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // Address counter; page writes only move the low nibble
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_r <= 8'h00;
        end else if (byte_end && kind_r == spd_pkg::KIND_ADDR
                     && op_r == spd_pkg::OP_MEM) begin
            addr_r <= shreg_r;
        end else if (data_push) begin
            addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
        end else if (tx_load) begin
            addr_r <= addr_r + 8'h01;
        end
    end

    page_fifo #(.W(`FIFO_W), .D(`PAGE_DEPTH)) u_page (
        .clk       (clk),
        .arst_n    (arst_n),
        .clr       ((stop_c && !begin_wr && state_r != spd_pkg::ST_BUSY)
                    || (start_c && state_r != spd_pkg::ST_BUSY)),
        .in_valid  (data_push),
        .in_ready  (f_in_ready),
        .in_data   ({addr_r, shreg_r}),
        .out_valid (f_out_valid),
        .out_ready (f_pop),
        .out_data  (f_out_data)
    );

    // Array commit from the page buffer during the write cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `MEM_DEPTH; i++) begin
                mem_r[i] <= `MEM_RESET;
            end
        end else if (f_pop && f_out_valid) begin
            mem_r[f_out_data[15:8]] <= f_out_data[7:0];
        end
    end

    // Write-cycle timer and pacing enable for buffer drain
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tw_cnt_r <= 24'h000000;
            pace_r   <= 4'h0;
            write_busy <= 1'b0;
        end else begin
            write_busy <= begin_wr
                       || (state_r == spd_pkg::ST_BUSY && !wr_done);
            if (begin_wr) begin
                tw_cnt_r <= 24'h000000;
                pace_r   <= `WR_PACE_CYC;
            end else if (state_r == spd_pkg::ST_BUSY) begin
                pace_r <= (pace_r == '0) ? `WR_PACE_CYC : pace_r - 4'h1;
                if (tw_cnt_r != 24'hFFFFFF) begin
                    tw_cnt_r <= tw_cnt_r + 24'h000001;
                end
            end
        end
    end

    // Protection state; reloaded once from the outside store
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loaded_r  <= 1'b0;
            soft_prot <= 1'b0;
            perm_prot <= 1'b0;
        end else if (!loaded_r) begin
            loaded_r  <= 1'b1;
            soft_prot <= nv_soft_prot_init || nv_perm_prot_init;
            perm_prot <= nv_perm_prot_init;
        end else if (begin_wr) begin
            case (op_r)
                spd_pkg::OP_SWP:  soft_prot <= 1'b1;
                spd_pkg::OP_CWP:  soft_prot <= perm_prot;
                spd_pkg::OP_PERMANENT_PROTECT_CMD: begin
                    soft_prot <= 1'b1;
                    perm_prot <= 1'b1;
                end
                default: soft_prot <= soft_prot;
            endcase
        end
    end

    // Data output is always a pulled-low drive
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_busy_no_drive: assert property (
        state_r == spd_pkg::ST_BUSY |=> !sda_oe)
        else $error("data line driven during write cycle");
    a_guard_blocks: assert property (
        data_push |-> !guard_s)
        else $error("byte buffered while guard high");
    a_low_half_lock: assert property (
        data_push && (soft_prot || perm_prot) |-> addr_r[7])
        else $error("write into locked lower half");
    a_perm_sticky: assert property (
        loaded_r && perm_prot |=> perm_prot)
        else $error("permanent lock released");
    a_lock_no_ack: assert property (
        byte_end && kind_r == spd_pkg::KIND_SEL && perm_prot
        && shreg_r[7:4] == `TYPE_PROT |=> !sda_oe)
        else $error("settings select acknowledged after lock");
    a_page_wrap: assert property (
        data_push |=> addr_r == {$past(addr_r[7:4]),
                                 $past(addr_r[3:0]) + 4'h1})
        else $error("page counter left its page");
    a_read_inc: assert property (
        tx_load |=> addr_r == $past(addr_r) + 8'h01)
        else $error("read counter not incremented");
    a_stop_trigger: assert property (
        $rose(write_busy) |-> $past(stop_c) && $past(armed_r))
        else $error("write cycle without stop after data ack");
    a_cs_match: assert property (
        byte_end && kind_r == spd_pkg::KIND_SEL
        && shreg_r[7:4] == `TYPE_MEM && shreg_r[3:1] != pins_s
        |=> !sda_oe ##1 state_r != spd_pkg::ST_TX)
        else $error("select acknowledged with wrong chip bits");
endmodule // spd_eeprom_i2c_slave

/* File: verification/i2c_mstr.sv */
// Behavioural two-wire bus master for the EEPROM slave engine.
// Assumes the data wire is resolved outside with a pull-up.
`timescale 1ns/10ps

module i2c_mstr (
    // Pacing clock
    input  wire logic clk,
    // Serial bus
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    localparam int HALF = 4; // Four clocks a phase: 160 ns link period

    // Idle bus: both lines released high
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One slot; data moves only while the clock is low
    task automatic slot(input logic b, output logic seen);
        scl <= 1'b0;
        tick(HALF / 2);
        sda_m <= b;
        tick(HALF / 2);
        scl <= 1'b1;
        tick(HALF - 2);
        seen = sda; // Mid high phase, well settled
        tick(2);
    endtask

    // Start or repeated start
    task automatic start();
        logic d;
        slot(1'b1, d);
        sda_m <= 1'b0;
        tick(HALF);
    endtask

    // Stop, clock then stays high until the next frame
    task automatic stop();
        logic d;
        slot(1'b0, d);
        sda_m <= 1'b1;
        tick(HALF);
    endtask

    // Byte out, most significant bit first, then ack slot
    task automatic tx(input logic [7:0] b, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            slot(b[i], d);
        end
        slot(1'b1, d);
        ack = ~d;
    endtask

    // Byte in, then our own ack or no-ack
    task automatic rx(input logic ack, output logic [7:0] b);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, d);
            b[i] = d;
        end
        slot(~ack, d);
    endtask
endmodule // i2c_mstr

/* File: verification/testbench.sv */
// Self-checking bench for the presence-detect EEPROM slave engine.
// Assumes the bus master model and a short write cycle parameter.
`timescale 1ns/10ps

module testbench;
    logic       clk, arst_n, scl, sda_m, sda, sda_oe, sda_out;
    logic       hv, guard, nv_soft, nv_perm, soft_prot, perm_prot;
    logic       write_busy;
    logic [2:0] pins;
    int         errors, n_tests;

    // Open drain wire with pull-up
    assign sda = sda_m & ~(sda_oe & ~sda_out);

    spd_eeprom_i2c_slave #(.TW_CYCLES(2000)) spd_eeprom_i2c_slave_i (
        .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_pin0(pins[0]),
        .chip_sel_pin1(pins[1]), .chip_sel_pin2(pins[2]),
        .high_voltage_level(hv), .write_guard_n(guard),
        .nv_soft_prot_init(nv_soft), .nv_perm_prot_init(nv_perm),
        .soft_prot(soft_prot), .perm_prot(perm_prot),
        .write_busy(write_busy));
    i2c_mstr i2c_mstr_i (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic put(input logic [7:0] b, input logic e);
        logic a;
        i2c_mstr_i.tx(b, a);
        chk({7'h00, a}, {7'h00, e});
    endtask

    task automatic busy(input logic e);
        #1;
        chk({7'h00, write_busy}, {7'h00, e});
    endtask

    // Bounded wait for the write cycle to end
    task automatic settle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        busy(1'b0);
    endtask

    task automatic wr(input logic [7:0] s, a, d, input logic e);
        i2c_mstr_i.start();
        put(s, 1'b1);
        put(a, 1'b1);
        put(d, e);
        i2c_mstr_i.stop();
    endtask

    // Random read: dummy write, restart, same upper select bits
    task automatic rd(input logic [7:0] a, exp);
        logic [7:0] v;
        i2c_mstr_i.start();
        put(8'hA0, 1'b1);
        put(a, 1'b1);
        i2c_mstr_i.start();
        put(8'hA1, 1'b1);
        i2c_mstr_i.rx(1'b0, v);
        i2c_mstr_i.stop();
        chk(v, exp);
    endtask

    task automatic t_select();
        logic [7:0] s[4] = '{8'hA2, 8'hAE, 8'hB0, 8'h21};
        foreach (s[i]) begin
            i2c_mstr_i.start();
            put(s[i], 1'b0);
            i2c_mstr_i.stop();
        end
    endtask

    task automatic t_byte();
        logic [7:0] v;
        wr(8'hA0, 8'h85, 8'h5A, 1'b1);
        busy(1'b1);
        i2c_mstr_i.start();
        put(8'hA0, 1'b0);
        i2c_mstr_i.stop();
        settle();
        i2c_mstr_i.start();
        put(8'hA0, 1'b1);
        i2c_mstr_i.stop();
        rd(8'h85, 8'h5A);
        i2c_mstr_i.start();
        put(8'hA1, 1'b1);
        i2c_mstr_i.rx(1'b0, v);
        i2c_mstr_i.stop();
        chk(v, 8'hFF);
    endtask

    // Overfull page is refused whole; a full page wraps in its page
    task automatic t_page();
        logic [7:0] v;
        for (int n = 17; n >= 16; n--) begin
            i2c_mstr_i.start();
            put(8'hA0, 1'b1);
            put(8'h1E, 1'b1);
            for (int i = 0; i < n; i++) begin
                put(8'h40 + 8'(i), i < 16);
            end
            i2c_mstr_i.stop();
            busy(n == 16);
        end
        settle();
        rd(8'h10, 8'h42);
        i2c_mstr_i.start();
        put(8'hA1, 1'b1);
        i2c_mstr_i.rx(1'b1, v);
        chk(v, 8'h43);
        i2c_mstr_i.rx(1'b0, v);
        chk(v, 8'h44);
        i2c_mstr_i.rx(1'b0, v);
        chk(v, 8'hFF);
        i2c_mstr_i.stop();
    endtask

    task automatic t_protect();
        guard <= 1'b1;
        wr(8'hA0, 8'h90, 8'h11, 1'b0);
        busy(1'b0);
        guard <= 1'b0;
        hv <= 1'b1;
        wr(8'h62, 8'h00, 8'h00, 1'b1);
        settle();
        chk({7'h00, soft_prot}, 8'h01);
        wr(8'hA0, 8'h10, 8'h77, 1'b0);
        pins <= 3'b010;
        wr(8'h66, 8'h00, 8'h00, 1'b1);
        settle();
        chk({7'h00, soft_prot}, 8'h00);
        pins <= 3'b000;
        hv <= 1'b0;
        wr(8'hA0, 8'h90, 8'h77, 1'b1);
        settle();
        wr(8'h60, 8'h00, 8'h00, 1'b1);
        settle();
        chk({7'h00, perm_prot}, 8'h01);
        hv <= 1'b1;
        i2c_mstr_i.start();
        put(8'h66, 1'b0);
        i2c_mstr_i.stop();
        rd(8'h10, 8'h42);
        rd(8'h90, 8'h77);
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog, about five times the expected run
    initial begin
        #2000000;
        errors++;
        test_done();
    end

    // Main sequence; a second reset stands in for a power cycle
    initial begin
        {arst_n, hv, guard, nv_soft, nv_perm, pins} = '0;
        errors = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_select();
        t_byte();
        t_page();
        t_protect();
        arst_n <= 1'b0;
        nv_perm <= 1'b1;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({6'h00, soft_prot, perm_prot}, 8'h03);
        test_done();
    end
endmodule // testbench
